// >>> design/stc_compress.v
// Linear to 8-bit log compressor, mu-law and A-law.
// Assumes a 16-bit left-justified linear input; purely combinational.
`timescale 1ns/1ps
`include "stc_defines.vh"
module stc_compress (
  input wire [15:0] i_lin,
  input wire [1:0] i_law,
  output reg [7:0] o_code
);

  reg [13:0] mu_x;
  reg [13:0] mu_mag;
  reg [12:0] al_x;
  reg [11:0] al_mag;
  reg [2:0] seg;
  reg [13:0] sh;
  integer i;

  ////////////////////////////////////////////////////////////////////////
  // Segment search, then mantissa; clip keeps the biased value in range
  always @* begin
    mu_x = i_lin[15:2];
    al_x = i_lin[15:3];
    mu_mag = mu_x[13] ? (~mu_x + 14'h0001) : mu_x;
    al_mag = al_x[12] ? ~al_x[11:0] : al_x[11:0];
    seg = 3'h0;
    sh = 14'h0000;
    o_code = 8'h00;
    if (i_law == `STC_CMP_MU) begin
      if (mu_mag > `STC_MU_CLIP) begin
        mu_mag = `STC_MU_CLIP;
      end
      mu_mag = mu_mag + `STC_MU_BIAS;
      for (i = 0; i < 8; i = i + 1) begin
        if (mu_mag[i + 5]) begin
          seg = i[2:0];
        end
      end
      sh = mu_mag >> ({1'b0, seg} + 4'h1);
      o_code = ~{mu_x[13], seg, sh[3:0]};
    end else if (i_law == `STC_CMP_AL) begin
      for (i = 5; i < 12; i = i + 1) begin
        if (al_mag[i]) begin
          seg = i[2:0] - 3'h4;
        end
      end
      sh = (seg == 3'h0) ? {3'h0, al_mag[11:1]} : {2'h0, al_mag >> seg};
      o_code = {~al_x[12], seg, sh[3:0]} ^ `STC_AL_XOR;
    end
  end

endmodule

// >>> design/stc_expand.v
// 8-bit log to 16-bit left-justified linear expander.
// Assumes mu-law or A-law select; other selects give zero.
`timescale 1ns/1ps
`include "stc_defines.vh"
module stc_expand (
  input wire [7:0] i_code,
  input wire [1:0] i_law,
  output reg [15:0] o_lin
);

  reg [7:0] c;
  reg [15:0] t;

  ////////////////////////////////////////////////////////////////////////
  // Rebuild segment base plus half step, then apply sign
  always @* begin
    c = 8'h00;
    t = 16'h0000;
    o_lin = 16'h0000;
    if (i_law == `STC_CMP_MU) begin
      c = ~i_code;
      t = (({12'h000, c[3:0]} << 3) + `STC_MU_DBIAS) << c[6:4];
      t = t - `STC_MU_DBIAS;
      o_lin = c[7] ? (~t + 16'h0001) : t;
    end else if (i_law == `STC_CMP_AL) begin
      c = i_code ^ `STC_AL_XOR;
      t = {8'h00, c[3:0], 4'h8};
      if (c[6:4] != 3'h0) begin
        t = (t + `STC_AL_STEP) << (c[6:4] - 3'h1);
      end
      o_lin = c[7] ? t : (~t + 16'h0001);
    end
  end

endmodule

// >>> design/stc_tx_core.v
// Serial port transmit exception logic and companding datapath.
// Assumes a register master on i_core_clk and a bit clock and frame
// sync from outside that are sampled by i_core_clk.
//
// Function
// - Underflow flag goes low when last bit sent and buffer not refilled.
// - Underflow flag is low after transmitter or device reset and restart.
// - During underflow each new frame sync resends the stale buffer word.
// - Underflow clears when a fresh buffer word reaches the shifter.
// - Copy-driven frame sync fires only after new data is copied.
// - Leaving transmitter reset shows ready high and underflow low.
// - A write before the first frame sync is copied for the first word.
// - A frame sync before any write sends zeros; mu-law and A-law selects send the code of zero.
// - Transmitter reset clears the sync error flag.
// - Sync earlier than data delay before last bit is unexpected.
// - With ignore set, unexpected syncs leave the word untouched.
// - First sync after enable, or one in the gap, is normal.
// - With ignore clear, an unexpected sync sets the sync error flag.
// - Sync error stays set until transmitter reset or software clear.
// - Interrupt mode 11b routes sync error to the transmit interrupt.
// - Software writing one to the sync error flag raises it.
// - Compander saturates out-of-range linear input to extreme codes.
// - Companded words are always eight bits whatever the word length.
// - Compress on buffer-to-shifter copy, expand on receive copy.
// - Justify field places expanded word: low zero, low sign, high.
// - Unexpected sync with ignore clear restarts the same word.
// - Select 01b with 8-bit words sends the byte LSB first.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "stc_defines.vh"
module stc_tx_core #(
  parameter ADDR_W = `STC_ADDR_W
) (
  input wire i_core_clk,
  input wire i_srst,
  input wire i_clk_en,
  input wire [ADDR_W-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire i_bit_clk,
  input wire i_fsync_in,
  input wire i_fsgen,
  output wire o_fsync_out,
  output wire o_fsync_oe_n,
  output wire o_serial_data_out,
  input wire [31:0] i_rx_hold_word,
  input wire i_rx_hold_load,
  output wire o_tx_ready,
  output wire o_tx_underflow_n,
  output reg o_tx_irq
);

  localparam ST_IDLE = 2'h0;
  localparam ST_DELAY = 2'h1;
  localparam ST_SHIFT = 2'h2;

  // Byte bit reversal for LSB-first 8-bit words
  function [7:0] stc_rev8;
    input [7:0] b;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        stc_rev8[k] = b[7 - k];
      end
    end
  endfunction

  // Word length code to bit count
  function [5:0] stc_wlen;
    input [2:0] code;
    begin
      case (code)
        3'h1: stc_wlen = `STC_WLEN_12;
        3'h2: stc_wlen = `STC_WLEN_16;
        3'h3: stc_wlen = `STC_WLEN_20;
        3'h4: stc_wlen = `STC_WLEN_24;
        3'h5: stc_wlen = `STC_WLEN_32;
        default: stc_wlen = `STC_WLEN_8;
      endcase
    end
  endfunction

  // Mu-law or A-law selected
  function stc_is_law;
    input [1:0] sel;
    begin
      stc_is_law = (sel == `STC_CMP_MU) | (sel == `STC_CMP_AL);
    end
  endfunction

  reg bclk_s1_q, bclk_s2_q, bclk_s3_q;
  reg fs_s1_q, fs_s2_q, fsp_q, fso_q;
  reg txen_q;
  reg [1:0] irqm_q, just_q;
  reg [`STC_DCR_W-1:0] dcr_q;
  reg [31:0] buf_q, word_q, sh_q, rxreg_q;
  reg buf_full_q, loaded_q, pend_q, und_n_q, err_q, dx_q;
  reg [1:0] state_q, cnt_q;
  reg [5:0] bits_q;
  reg [31:0] load_val, rd_mux, rx_val;
  wire [7:0] comp_code;
  wire [15:0] exp_lin;

  wire [1:0] txc = dcr_q[`STC_DCR_TXC];
  wire [1:0] rxc = dcr_q[`STC_DCR_RXC];
  wire [1:0] dly = dcr_q[`STC_DCR_DLY];
  wire dir = dcr_q[`STC_DCR_DIR];
  wire ign = dcr_q[`STC_DCR_IGN];
  wire int_copy = dir & ~dcr_q[`STC_DCR_GEN];
  wire [5:0] wl_raw = stc_wlen(dcr_q[`STC_DCR_WL]);
  wire [5:0] wlen = stc_is_law(txc) ? `STC_WLEN_8 : wl_raw;
  wire bit_rise = bclk_s2_q & ~bclk_s3_q;
  wire fs_lvl = dir ? fso_q : fs_s2_q;
  wire fs_ev = txen_q & bit_rise & fs_lvl & ~fsp_q;
  // Sync arriving more than data-delay bits before the end
  wire unexp = (state_q == ST_SHIFT) & (bits_q > {4'h0, dly});
  wire err_set = fs_ev & unexp & ~ign;
  // Ignored syncs fall through so the word in flight keeps shifting
  wire fs_take = fs_ev & ~(unexp & ign);
  wire shift_now = bit_rise &
    ((state_q == ST_SHIFT) | ((state_q == ST_DELAY) & (cnt_q == 2'h0)));
  wire wr_buf = i_wr & (i_addr == `STC_OFS_TXBUF) & txen_q;
  wire wr_pcr = i_wr & (i_addr == `STC_OFS_PCR);
  wire wr_dcr = i_wr & (i_addr == `STC_OFS_DCR);

  assign o_fsync_out = fso_q;
  assign o_fsync_oe_n = ~dir;
  assign o_serial_data_out = dx_q;
  assign o_tx_ready = ~buf_full_q & txen_q;
  assign o_tx_underflow_n = und_n_q;

  stc_compress u_comp (
    .i_lin(buf_q[15:0]),
    .i_law(txc),
    .o_code(comp_code)
  );

  stc_expand u_exp (
    .i_code(i_rx_hold_word[7:0]),
    .i_law(rxc),
    .o_lin(exp_lin)
  );

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      bclk_s1_q <= 1'b0;
      bclk_s2_q <= 1'b0;
      bclk_s3_q <= 1'b0;
      fs_s1_q <= 1'b0;
      fs_s2_q <= 1'b0;
    end else if (i_clk_en) begin
      bclk_s1_q <= i_bit_clk;
      bclk_s2_q <= bclk_s1_q;
      bclk_s3_q <= bclk_s2_q;
      fs_s1_q <= i_fsync_in;
      fs_s2_q <= fs_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shifter image of the buffer: compressed, reversed or left-aligned
  always @* begin
    if (stc_is_law(txc)) begin
      load_val = {comp_code, 24'h000000};
    end else if ((txc == `STC_CMP_LSB) && (wlen == `STC_WLEN_8)) begin
      load_val = {stc_rev8(buf_q[7:0]), 24'h000000};
    end else begin
      load_val = buf_q << (`STC_WLEN_32 - wlen);
    end
  end

  // Frame start copy: fresh if refilled, stale buffer if nothing was early-copied
  task stc_load;
    begin
      if (buf_full_q) begin
        sh_q <= load_val;
        word_q <= load_val;
        buf_full_q <= 1'b0;
        und_n_q <= 1'b1;
      end else if (!loaded_q) begin
        sh_q <= load_val;
        word_q <= load_val;
      end
      loaded_q <= 1'b0;
      bits_q <= wlen;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Transmit sequencer: idle, data delay, shifting
  always @(posedge i_core_clk) begin
    if (i_srst || (i_clk_en && !txen_q)) begin
      // Held in reset: ready low, underflow low, buffer zero
      state_q <= ST_IDLE;
      buf_q <= 32'h00000000;
      buf_full_q <= 1'b0;
      und_n_q <= 1'b0;
      word_q <= 32'h00000000;
      sh_q <= 32'h00000000;
      loaded_q <= 1'b0;
      pend_q <= 1'b0;
      dx_q <= 1'b0;
      fsp_q <= 1'b0;
      fso_q <= 1'b0;
      cnt_q <= 2'h0;
      bits_q <= 6'h00;
    end else if (i_clk_en) begin
      if (bit_rise) begin
        fsp_q <= fs_lvl;
      end
      // Copy-driven sync waits for a loaded word
      if (int_copy) begin
        if (bit_rise) begin
          fso_q <= (state_q == ST_IDLE) & loaded_q & ~fso_q;
        end
      end else if (dir) begin
        fso_q <= i_fsgen;
      end else begin
        fso_q <= 1'b0;
      end
      if (err_set) begin
        // Abort and resend the same word after the delay
        sh_q <= word_q;
        bits_q <= wlen;
        state_q <= ST_DELAY;
        cnt_q <= dly;
        pend_q <= 1'b0;
      end else if (fs_take && (state_q == ST_SHIFT)) begin
        pend_q <= 1'b1;
      end else if (fs_take) begin
        stc_load;
        state_q <= ST_DELAY;
        cnt_q <= dly;
      end else if (shift_now) begin
        dx_q <= sh_q[31];
        sh_q <= sh_q << 1;
        bits_q <= bits_q - 6'h01;
        state_q <= ST_SHIFT;
        if (bits_q == 6'h01) begin
          if (!buf_full_q) begin
            und_n_q <= 1'b0;
          end
          if (pend_q) begin
            // Gap sync already seen: next word follows at once
            pend_q <= 1'b0;
            stc_load;
          end else begin
            state_q <= ST_IDLE;
          end
        end
      end else if (bit_rise && (state_q == ST_DELAY)) begin
        cnt_q <= cnt_q - 2'h1;
      end else if ((state_q == ST_IDLE) && buf_full_q && !loaded_q) begin
        // Early copy so the first word of the first frame is valid
        sh_q <= load_val;
        word_q <= load_val;
        buf_full_q <= 1'b0;
        loaded_q <= 1'b1;
        und_n_q <= 1'b1;
      end
      // A write in the copy cycle stays pending for the next copy
      if (wr_buf) begin
        buf_q <= i_wdata;
        buf_full_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sync error flag: hardware set beats a software clear
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      err_q <= 1'b0;
    end else if (i_clk_en) begin
      if (!txen_q) begin
        err_q <= 1'b0;
      end else if (err_set) begin
        err_q <= 1'b1;
      end else if (wr_pcr) begin
        err_q <= i_wdata[`STC_PCR_ERR];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      txen_q <= 1'b0;
      irqm_q <= `STC_IRQ_READY;
      just_q <= `STC_JUST_ZERO;
      dcr_q <= `STC_DCR_RST;
    end else if (i_clk_en) begin
      if (wr_pcr) begin
        txen_q <= i_wdata[`STC_PCR_TXEN];
        irqm_q <= i_wdata[`STC_PCR_IRQM];
        just_q <= i_wdata[`STC_PCR_JUST];
      end
      if (wr_dcr) begin
        dcr_q <= i_wdata[`STC_DCR_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive copy: expand and justify, or reverse, or pass through
  always @* begin
    if (stc_is_law(rxc)) begin
      if (just_q == `STC_JUST_SIGN) begin
        rx_val = {{16{exp_lin[15]}}, exp_lin};
      end else if (just_q == `STC_JUST_HIGH) begin
        rx_val = {exp_lin, 16'h0000};
      end else begin
        rx_val = {16'h0000, exp_lin};
      end
    end else if (rxc == `STC_CMP_LSB) begin
      rx_val = {24'h000000, stc_rev8(i_rx_hold_word[7:0])};
    end else begin
      rx_val = i_rx_hold_word;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_srst) begin
      rxreg_q <= 32'h00000000;
    end else if (i_clk_en && i_rx_hold_load) begin
      rxreg_q <= rx_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read decode; unmapped offsets read zero
  always @* begin
    rd_mux = 32'h00000000;
    if (i_addr == `STC_OFS_TXBUF) begin
      rd_mux = buf_q;
    end else if (i_addr == `STC_OFS_RXREAD) begin
      rd_mux = rxreg_q;
    end else if (i_addr == `STC_OFS_PCR) begin
      rd_mux[`STC_PCR_TXEN] = txen_q;
      rd_mux[`STC_PCR_READY] = o_tx_ready;
      rd_mux[`STC_PCR_UNDN] = und_n_q;
      rd_mux[`STC_PCR_ERR] = err_q;
      rd_mux[`STC_PCR_IRQM] = irqm_q;
      rd_mux[`STC_PCR_JUST] = just_q;
    end else if (i_addr == `STC_OFS_DCR) begin
      rd_mux[`STC_DCR_W-1:0] = dcr_q;
    end
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_rdata <= 32'h00000000;
      o_tx_irq <= 1'b0;
    end else if (i_clk_en) begin
      o_rdata <= i_rd ? rd_mux : 32'h00000000;
      if (irqm_q == `STC_IRQ_SYNCERR) begin
        o_tx_irq <= err_q;
      end else if (irqm_q == `STC_IRQ_READY) begin
        o_tx_irq <= o_tx_ready;
      end else begin
        o_tx_irq <= 1'b0;
      end
    end
  end

endmodule

// >>> shared/stc_defines.vh
// Constants shared by the serial transmit error and compand block.
// Assumes a 4-bit byte address on the register port, 32-bit words.
`ifndef STC_DEFINES_VH
`define STC_DEFINES_VH

////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define STC_ADDR_W 4
`define STC_OFS_TXBUF 4'h0
`define STC_OFS_RXREAD 4'h4
`define STC_OFS_PCR 4'h8
`define STC_OFS_DCR 4'hC

// Port control register fields
`define STC_PCR_TXEN 0
`define STC_PCR_READY 1
`define STC_PCR_UNDN 2
`define STC_PCR_ERR 3
`define STC_PCR_IRQM 5:4
`define STC_PCR_JUST 7:6

// Direction control register fields
`define STC_DCR_TXC 1:0
`define STC_DCR_RXC 3:2
`define STC_DCR_IGN 4
`define STC_DCR_DLY 6:5
`define STC_DCR_WL 10:8
`define STC_DCR_DIR 12
`define STC_DCR_GEN 13
`define STC_DCR_W 14
`define STC_DCR_RST 14'h0000

////////////////////////////////////////////////////////////////////////
// Compand select, interrupt mode and justify codes
`define STC_CMP_NONE 2'h0
`define STC_CMP_LSB 2'h1
`define STC_CMP_MU 2'h2
`define STC_CMP_AL 2'h3
`define STC_IRQ_READY 2'h0
`define STC_IRQ_SYNCERR 2'h3
`define STC_JUST_ZERO 2'h0
`define STC_JUST_SIGN 2'h1
`define STC_JUST_HIGH 2'h2

// Word lengths in bits, as loaded into the bit counter
`define STC_WLEN_8 6'h08
`define STC_WLEN_12 6'h0C
`define STC_WLEN_16 6'h10
`define STC_WLEN_20 6'h14
`define STC_WLEN_24 6'h18
`define STC_WLEN_32 6'h20

// Companding law constants
`define STC_MU_CLIP 14'h1FDE
`define STC_MU_BIAS 14'h0021
`define STC_MU_DBIAS 16'h0084
`define STC_AL_XOR 8'h55
`define STC_AL_STEP 16'h0100

`endif

// >>> tb/stc_codec_model.sv
// Far-side codec: makes the bit clock and frame sync, captures words.
// Assumes the device moves data on bit clock rise; sampled on the fall.
`timescale 1ns/1ps
module stc_codec_model (
  input wire i_serial_data,
  output reg o_bit_clk,
  output reg o_fsync,
  output reg [31:0] o_word,
  output reg o_word_vld
);
  reg run;
  integer i;

  // Bit clock of 160 ns, parked low between frames, phase off the core
  initial begin
    o_bit_clk = 1'b0;
    o_fsync = 1'b0;
    o_word = 32'h0;
    o_word_vld = 1'b0;
    run = 1'b0;
    #3;
    forever begin
      #80;
      if (run || o_bit_clk) o_bit_clk = ~o_bit_clk;
    end
  end

  // Plain bit clocks, no sync; the device owns the pin then
  task clocks(input integer n);
    begin
      run = 1'b1;
      repeat (n) @(negedge o_bit_clk);
      run = 1'b0;
    end
  endtask

  // Sync for two bits, then n bits MSB first; an extra sync at bit k,
  // and with rs set the capture restarts after it
  task frame(input integer n, input integer k, input integer rs);
    begin
      run = 1'b1;
      o_word = 32'h0;
      @(negedge o_bit_clk);
      o_fsync = 1'b1;
      @(negedge o_bit_clk);
      for (i = 0; i < n; i = i + 1) begin
        @(negedge o_bit_clk);
        o_fsync = 1'b0;
        o_word = {o_word[30:0], i_serial_data};
        if (i == k) begin
          o_fsync = 1'b1;
          k = -1;
          if (rs != 0) begin
            @(negedge o_bit_clk);
            o_fsync = 1'b0;
            i = -1;
            o_word = 32'h0;
          end
        end
      end
      // One spare bit so the device can see its last bit go out
      @(negedge o_bit_clk);
      run = 1'b0;
      o_word_vld = 1'b1;
      #20 o_word_vld = 1'b0;
    end
  endtask
endmodule

// >>> tb/stc_tx_core_asserts.sv
// Port-level checks for the serial transmit core.
// Assumes binding into stc_tx_core; fields are shadowed from bus writes.
`timescale 1ns/1ps
`include "stc_defines.vh"
module stc_tx_core_asserts #(
  parameter ADDR_W = `STC_ADDR_W
) (
  input wire i_core_clk,
  input wire i_srst,
  input wire i_clk_en,
  input wire [ADDR_W-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire i_bit_clk,
  input wire i_fsync_in,
  input wire i_fsgen,
  input wire o_fsync_out,
  input wire o_fsync_oe_n,
  input wire o_serial_data_out,
  input wire [31:0] i_rx_hold_word,
  input wire i_rx_hold_load,
  input wire o_tx_ready,
  input wire o_tx_underflow_n,
  input wire o_tx_irq
);
  localparam [ADDR_W-1:0] A_BUF = 0;
  localparam [ADDR_W-1:0] A_PCR = 8;
  localparam [ADDR_W-1:0] A_DCR = 12;
  reg txen_q, dir_q, wseen_q, und_q, b1_q, b2_q;
  reg [1:0] irqm_q;
  reg [7:0] since_q;
  wire wr_ok = i_wr && i_clk_en;

  ////////////////////////////////////////
  // Shadow fields; wseen marks a buffer word not yet seen as a copy
  always @(posedge i_core_clk) begin
    b1_q <= i_bit_clk;
    b2_q <= b1_q;
    since_q <= (b1_q && !b2_q) ? 8'h00 : since_q + {7'h0, since_q != 8'hFF};
    if (i_srst) begin
      txen_q <= 1'b0;
      dir_q <= 1'b0;
      irqm_q <= 2'h0;
      wseen_q <= 1'b0;
      und_q <= 1'b0;
    end else begin
      und_q <= o_tx_underflow_n;
      if (wr_ok && i_addr == A_PCR) begin
        txen_q <= i_wdata[0];
        irqm_q <= i_wdata[5:4];
      end
      if (wr_ok && i_addr == A_DCR) dir_q <= i_wdata[12];
      if (wr_ok && i_addr == A_BUF && txen_q) wseen_q <= 1'b1;
      else if (o_tx_underflow_n && !und_q) wseen_q <= 1'b0;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  ////////////////////////////////////////
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside read slot");
  AST_UNMAPPED_RD: assert property
    (i_rd && i_addr[1:0] != 2'h0 |=> o_rdata == 32'h0)
    else $error("unmapped read returned data");
  AST_DIS_QUIET: assert property
    (!txen_q && !$past(txen_q) |-> !o_tx_ready && !o_tx_underflow_n)
    else $error("disabled transmitter shows ready or no underflow");
  AST_ENABLE_STATE: assert property
    ($rose(txen_q) |-> o_tx_ready && !o_tx_underflow_n)
    else $error("wrong flags after enable");
  AST_WRITE_FULL: assert property
    (i_wr && i_addr == A_BUF && txen_q |=> !o_tx_ready)
    else $error("ready stayed high after buffer write");
  AST_UNDER_CLEAR: assert property
    ($rose(o_tx_underflow_n) |-> wseen_q)
    else $error("underflow cleared without a new word");
  AST_IRQ_READY: assert property
    (irqm_q == 2'h0 |=> o_tx_irq == $past(o_tx_ready))
    else $error("interrupt does not follow ready");
  AST_IRQ_OTHER: assert property
    (irqm_q == 2'h1 || irqm_q == 2'h2 |=> !o_tx_irq)
    else $error("interrupt high in an unused mode");
  AST_PIN_INPUT: assert property
    (!dir_q && !$past(dir_q) |-> o_fsync_oe_n)
    else $error("frame sync pin driven in input mode");
  AST_SYNC_WIDTH: assert property
    ($rose(o_fsync_out) && !o_fsync_oe_n |-> o_fsync_out [*8])
    else $error("driven frame sync shorter than a bit");
  AST_DATA_ON_EDGE: assert property
    (txen_q && $past(txen_q) && $changed(o_serial_data_out)
     |-> since_q <= 8'h07)
    else $error("serial data changed away from a bit edge");

  COV_UNDER: cover property ($fell(o_tx_underflow_n));
  COV_IRQ: cover property (irqm_q == 2'h3 && o_tx_irq);
  COV_SYNC_OUT: cover property ($rose(o_fsync_out) && !o_fsync_oe_n);
endmodule

bind stc_tx_core stc_tx_core_asserts #(.ADDR_W(ADDR_W)) u_asserts (
  .i_core_clk(i_core_clk), .i_srst(i_srst), .i_clk_en(i_clk_en),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_bit_clk(i_bit_clk), .i_fsync_in(i_fsync_in),
  .i_fsgen(i_fsgen), .o_fsync_out(o_fsync_out),
  .o_fsync_oe_n(o_fsync_oe_n), .o_serial_data_out(o_serial_data_out),
  .i_rx_hold_word(i_rx_hold_word), .i_rx_hold_load(i_rx_hold_load),
  .o_tx_ready(o_tx_ready), .o_tx_underflow_n(o_tx_underflow_n),
  .o_tx_irq(o_tx_irq)
);

// >>> tb/tb_stc_tx_core.sv
// Self-checking bench for the serial transmit core.
// Assumes the codec model on the link and the checker bound by itself.
`timescale 1ns/1ps
`include "stc_defines.vh"
module tb_stc_tx_core;
  reg i_core_clk = 1'b0;
  reg i_srst = 1'b1;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg i_rx_hold_load = 1'b0;
  reg [3:0] i_addr = 4'h0;
  reg [31:0] i_wdata = 32'h0;
  reg [31:0] i_rx_hold_word = 32'h0;
  wire [31:0] o_rdata, cap_word;
  wire o_fsync_out, o_fsync_oe_n, o_serial_data_out;
  wire o_tx_ready, o_tx_underflow_n, o_tx_irq, bit_clk, m_fsync, cap_vld;
  // Pin level: the device wins while its enable is low
  wire fsync_pin = o_fsync_oe_n ? m_fsync : o_fsync_out;
  integer errors = 0;
  integer num_checks = 0;
  integer nsync = 0;
  integer j, s;
  reg rd_q = 1'b0;
  reg [7:0] b;
  reg [31:0] d, e;
  reg [31:0] exp_rd[$];
  reg [31:0] exp_tx[$];

  always #5 i_core_clk = ~i_core_clk;

  stc_tx_core u_dut (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_clk_en(1'b1),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_bit_clk(bit_clk), .i_fsync_in(fsync_pin),
    .i_fsgen(1'b0), .o_fsync_out(o_fsync_out),
    .o_fsync_oe_n(o_fsync_oe_n), .o_serial_data_out(o_serial_data_out),
    .i_rx_hold_word(i_rx_hold_word), .i_rx_hold_load(i_rx_hold_load),
    .o_tx_ready(o_tx_ready), .o_tx_underflow_n(o_tx_underflow_n),
    .o_tx_irq(o_tx_irq)
  );
  stc_codec_model u_codec (
    .i_serial_data(o_serial_data_out), .o_bit_clk(bit_clk),
    .o_fsync(m_fsync), .o_word(cap_word), .o_word_vld(cap_vld)
  );

  ////////////////////////////////////////
  task check(input string what, input [31:0] seen, input [31:0] x);
    begin
      num_checks = num_checks + 1;
      if (seen !== x) begin
        errors = errors + 1;
        $display("Error %s expected %h seen %h", what, x, seen);
      end
    end
  endtask
  task summarize;
    begin
      $display("Checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Bus cycles leave one idle edge so strobes never get two values at once
  task wr(input [3:0] a, input [31:0] v);
    begin
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
      @(posedge i_core_clk);
    end
  endtask
  task rd(input [3:0] a, input [31:0] x);
    begin
      exp_rd.push_back(x);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      @(posedge i_core_clk);
    end
  endtask
  task send(input [31:0] x, input integer k, input integer rs);
    begin
      exp_tx.push_back(x);
      u_codec.frame(8, k, rs);
      @(posedge i_core_clk);
    end
  endtask

  // Read data is taken only in the cycle after the strobe
  always @(posedge i_core_clk) begin
    rd_q <= i_rd;
    if (rd_q && exp_rd.size() > 0) check("rdata", o_rdata, exp_rd.pop_front());
  end
  always @(posedge cap_vld) check("txword", cap_word, exp_tx.pop_front());
  always @(posedge o_fsync_out) nsync = nsync + 1;

  ////////////////////////////////////////
  initial begin
    s = $urandom(32'h9208185c);
    repeat (6) @(posedge i_core_clk);
    i_srst <= 1'b0;
    @(posedge i_core_clk);
    wr(`STC_OFS_PCR, 32'h1);
    repeat (32) @(posedge i_core_clk);
    wr(`STC_OFS_PCR, 32'h0);
    wr(`STC_OFS_PCR, 32'h1);
    rd(`STC_OFS_PCR, 32'h3);
    rd(4'h2, 32'h0);
    send(32'h0, 99, 0);
    rd(`STC_OFS_PCR, 32'h3);
    // Each transmit select once; laws get a clipping input, wide words
    for (j = 0; j < 4; j = j + 1) begin
      b = $urandom;
      s = $urandom & 1;
      d = $urandom;
      if (j < 2) d[7:0] = b;
      else d[15:0] = s ? 16'h8000 : 16'h7FFF;
      case (j)
        0: e = {24'h0, b};
        1: e = {24'h0, b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
        2: e = s ? 32'h00 : 32'h80;
        default: e = s ? 32'h2A : 32'hAA;
      endcase
      wr(`STC_OFS_DCR, j + (j > 1 ? 32'h200 : 32'h0));
      wr(`STC_OFS_TXBUF, d);
      repeat (2) @(posedge i_core_clk);
      rd(`STC_OFS_PCR, 32'h7);
      send(e, 99, 0);
      rd(`STC_OFS_PCR, 32'h3);
      send(e, 99, 0);
    end
    // Early sync: restart, error, interrupt, clear, set, reset, ignore
    wr(`STC_OFS_DCR, 32'h0);
    wr(`STC_OFS_PCR, 32'h31);
    wr(`STC_OFS_TXBUF, {24'h0, b});
    send({24'h0, b}, 2, 1);
    rd(`STC_OFS_PCR, 32'h3B);
    check("irq", {31'h0, o_tx_irq}, 32'h1);
    wr(`STC_OFS_PCR, 32'h31);
    rd(`STC_OFS_PCR, 32'h33);
    wr(`STC_OFS_PCR, 32'h39);
    rd(`STC_OFS_PCR, 32'h3B);
    wr(`STC_OFS_PCR, 32'h18);
    wr(`STC_OFS_PCR, 32'h11);
    rd(`STC_OFS_PCR, 32'h13);
    wr(`STC_OFS_DCR, 32'h10);
    wr(`STC_OFS_TXBUF, {24'h0, ~b});
    send({24'h0, ~b}, 2, 0);
    rd(`STC_OFS_PCR, 32'h13);
    // Copy-driven sync: one pulse for one word, none while starved
    wr(`STC_OFS_DCR, 32'h1000);
    nsync = 0;
    wr(`STC_OFS_TXBUF, {24'h0, b});
    u_codec.clocks(24);
    u_codec.clocks(24);
    @(posedge i_core_clk);
    check("syncs", nsync, 32'h1);
    // Receive expansion under each justify code, A-law, and pass-through
    wr(`STC_OFS_DCR, 32'h8);
    for (j = 0; j < 5; j = j + 1) begin
      d = $urandom;
      case (j)
        0: e = 32'h00008284;
        1: e = 32'hFFFF8284;
        2: e = 32'h82840000;
        3: e = 32'h00007E00;
        default: e = d;
      endcase
      if (j == 3) wr(`STC_OFS_DCR, 32'hC);
      if (j == 4) wr(`STC_OFS_DCR, 32'h0);
      wr(`STC_OFS_PCR, (j < 3 ? j : 0) * 64 + 1);
      i_rx_hold_word <= j > 3 ? d : {d[31:8], j == 3 ? 8'hAA : 8'h00};
      i_rx_hold_load <= 1'b1;
      @(posedge i_core_clk);
      i_rx_hold_load <= 1'b0;
      @(posedge i_core_clk);
      rd(`STC_OFS_RXREAD, e);
    end
    summarize;
  end

  // Watchdog far beyond the some 30 us the sequence needs
  initial begin
    #400000;
    errors = errors + 1;
    summarize;
  end
endmodule
